// ==== hw/adc_input_select_and_test_decode.sv ====
`timescale 1ns/100ps
module adc_input_select_and_test_decode (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic wr_strobe,
	input wire logic register_select_bit1,
	input wire logic register_select_bit0,
	input wire logic [9:0] wr_data,
	input wire logic conv_step,
	input wire logic samples_ready_in,
	output adc_cfg_pkg::input_sel_t cur_input,
	output logic [1:0] selfcheck_sel,
	output logic samples_ready_flag,
	output logic scan_active,
	output logic [9:0] input_mode_word,
	output logic [9:0] host_if_word,
	output logic soft_reset_pulse,
	output logic queue_clear_pulse
);
	adc_cfg_pkg::input_mode_t mode_q, mode_d;
	adc_cfg_pkg::host_if_t host_q, host_d;
	logic [1:0] step_q, step_d;
	adc_cfg_pkg::input_sel_t sel_q, sel_d;
	logic flag_q, flag_d;
	logic srst_q, srst_d;
	logic qclr_q, qclr_d;
	logic [1:0] addr;
	logic wr_mode, wr_host;

	// length of scan sequence, 1 when not scanning
	function automatic logic [2:0] seq_len(input adc_cfg_pkg::input_mode_t m);
		logic [4:0] c;
		c = {m.scan, m.differential_count_bit1, m.differential_count_bit0,
			m.input_pick};
		unique case (c)
			5'h11: seq_len = 3'h2;
			5'h12: seq_len = 3'h3;
			5'h13: seq_len = 3'h4;
			5'h15: seq_len = 3'h2;
			5'h16: seq_len = 3'h3;
			5'h19: seq_len = 3'h2;
			default: seq_len = 3'h1;
		endcase
	endfunction : seq_len

	// input selected at a given scan step
	function automatic adc_cfg_pkg::input_sel_t sel_at(
		input adc_cfg_pkg::input_mode_t m, input logic [1:0] s);
		logic [4:0] c;
		c = {m.scan, m.differential_count_bit1, m.differential_count_bit0,
			m.input_pick};
		sel_at = adc_cfg_pkg::SEL_DIFF_A;
		unique case (c)
			5'h00: sel_at = adc_cfg_pkg::SEL_AP;
			5'h01: sel_at = adc_cfg_pkg::SEL_AM;
			5'h02: sel_at = adc_cfg_pkg::SEL_BP;
			5'h03: sel_at = adc_cfg_pkg::SEL_BM;
			5'h04: sel_at = adc_cfg_pkg::SEL_DIFF_A;
			5'h05: sel_at = adc_cfg_pkg::SEL_DIFF_B;
			5'h11, 5'h12, 5'h13: begin
				sel_at = adc_cfg_pkg::input_sel_t'({1'b0, s});
			end
			5'h15: begin
				sel_at = (s == 2'h0) ? adc_cfg_pkg::SEL_AP :
					adc_cfg_pkg::SEL_DIFF_B;
			end
			5'h16: begin
				if (s == 2'h0) begin
					sel_at = adc_cfg_pkg::SEL_AP;
				end else if (s == 2'h1) begin
					sel_at = adc_cfg_pkg::SEL_AM;
				end else begin
					sel_at = adc_cfg_pkg::SEL_DIFF_B;
				end
			end
			5'h19: begin
				sel_at = (s == 2'h0) ? adc_cfg_pkg::SEL_DIFF_A :
					adc_cfg_pkg::SEL_DIFF_B;
			end
			default: sel_at = adc_cfg_pkg::SEL_DIFF_A;
		endcase
	endfunction : sel_at

	assign addr = {register_select_bit1, register_select_bit0};
	assign wr_mode = wr_strobe && (addr == adc_cfg_pkg::ADDR_INPUT_MODE);
	assign wr_host = wr_strobe && (addr == adc_cfg_pkg::ADDR_HOST_IF);

	always_comb begin
		mode_d = mode_q;
		host_d = host_q;
		srst_d = 1'b0;
		qclr_d = 1'b0;
		if (wr_mode) begin
			mode_d = adc_cfg_pkg::input_mode_t'(wr_data);
		end
		if (wr_host) begin
			host_d = adc_cfg_pkg::host_if_t'(wr_data);
			host_d.reserved = 1'b0;
			host_d.soft_reset = 1'b0;
			host_d.overflow_or_queue_clear = 1'b0;
			srst_d = wr_data[adc_cfg_pkg::POS_RESET];
			qclr_d = wr_data[adc_cfg_pkg::POS_QCLR];
			if (wr_data[adc_cfg_pkg::POS_RESET]) begin
				mode_d = adc_cfg_pkg::input_mode_t'(adc_cfg_pkg::INPUT_MODE_RST);
				host_d = adc_cfg_pkg::host_if_t'(adc_cfg_pkg::HOST_IF_RST);
			end
		end
	end

	always_comb begin
		step_d = step_q;
		if (wr_mode || wr_host) begin
			step_d = 2'h0;
		end else if (conv_step) begin
			if ({1'b0, step_q} + 3'h1 >= seq_len(mode_q)) begin
				step_d = 2'h0;
			end else begin
				step_d = step_q + 2'h1;
			end
		end
		sel_d = sel_at(mode_d, step_d);
		// flag held inactive in test mode, else follows the source
		if (mode_d.selfcheck_sel != 2'h0) begin
			flag_d = ~host_d.flag_polarity;
		end else begin
			flag_d = samples_ready_in;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mode_q <= adc_cfg_pkg::input_mode_t'(adc_cfg_pkg::INPUT_MODE_RST);
			host_q <= adc_cfg_pkg::host_if_t'(adc_cfg_pkg::HOST_IF_RST);
			step_q <= 2'h0;
			sel_q <= adc_cfg_pkg::SEL_DIFF_A;
			flag_q <= 1'b0;
			srst_q <= 1'b0;
			qclr_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			host_q <= host_d;
			step_q <= step_d;
			sel_q <= sel_d;
			flag_q <= flag_d;
			srst_q <= srst_d;
			qclr_q <= qclr_d;
		end
	end

	assign cur_input = sel_q;
	assign selfcheck_sel = mode_q.selfcheck_sel;
	assign samples_ready_flag = flag_q;
	assign scan_active = mode_q.scan;
	assign input_mode_word = mode_q;
	assign host_if_word = host_q;
	assign soft_reset_pulse = srst_q;
	assign queue_clear_pulse = qclr_q;

	property p_mode_write;
		@(posedge core_clk) disable iff (sys_rst)
		wr_mode && !wr_host |=> input_mode_word == $past(wr_data);
	endproperty
	a_mode_write: assert property (p_mode_write)
		else $error("mode word not stored");

	property p_test_flag;
		@(posedge core_clk) disable iff (sys_rst)
		selfcheck_sel != 2'h0 |->
		samples_ready_flag == !host_if_word[adc_cfg_pkg::POS_FLAG_POL];
	endproperty
	a_test_flag: assert property (p_test_flag)
		else $error("flag active in test");

	property p_soft_reset;
		@(posedge core_clk) disable iff (sys_rst)
		wr_host && wr_data[adc_cfg_pkg::POS_RESET] |=>
			input_mode_word == adc_cfg_pkg::INPUT_MODE_RST &&
			host_if_word == adc_cfg_pkg::HOST_IF_RST && soft_reset_pulse;
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("soft reset wrong");

	property p_single;
		@(posedge core_clk) disable iff (sys_rst)
		input_mode_word[7:3] == 5'h02 |-> cur_input == adc_cfg_pkg::SEL_BP;
	endproperty
	a_single: assert property (p_single)
		else $error("single select wrong");

	property p_diff;
		@(posedge core_clk) disable iff (sys_rst)
		input_mode_word[7:3] == 5'h05 |-> cur_input == adc_cfg_pkg::SEL_DIFF_B;
	endproperty
	a_diff: assert property (p_diff)
		else $error("diff select wrong");

	sequence s_two_steps;
		conv_step && !wr_strobe ##1 conv_step && !wr_strobe;
	endsequence

	sequence s_one_step;
		conv_step && !wr_strobe;
	endsequence

	property p_scan_four;
		@(posedge core_clk) disable iff (sys_rst)
		input_mode_word[7:3] == 5'h13 && cur_input == adc_cfg_pkg::SEL_BM
		##0 s_two_steps |=> cur_input == adc_cfg_pkg::SEL_AM;
	endproperty
	a_scan_four: assert property (p_scan_four)
		else $error("scan four wrong");

	property p_scan_pair;
		@(posedge core_clk) disable iff (sys_rst)
		input_mode_word[7:3] == 5'h11 && cur_input == adc_cfg_pkg::SEL_AM
		##0 s_one_step |=> cur_input == adc_cfg_pkg::SEL_AP;
	endproperty
	a_scan_pair: assert property (p_scan_pair)
		else $error("scan two wrong");

	property p_scan_three;
		@(posedge core_clk) disable iff (sys_rst)
		input_mode_word[7:3] == 5'h12 && cur_input == adc_cfg_pkg::SEL_BP
		##0 s_one_step |=> cur_input == adc_cfg_pkg::SEL_AP;
	endproperty
	a_scan_three: assert property (p_scan_three)
		else $error("scan three wrong");

	property p_scan_mixed_pair;
		@(posedge core_clk) disable iff (sys_rst)
		input_mode_word[7:3] == 5'h15 && cur_input == adc_cfg_pkg::SEL_DIFF_B
		##0 s_one_step |=> cur_input == adc_cfg_pkg::SEL_AP;
	endproperty
	a_scan_mixed_pair: assert property (p_scan_mixed_pair)
		else $error("mixed pair scan wrong");

	property p_scan_mixed_three;
		@(posedge core_clk) disable iff (sys_rst)
		input_mode_word[7:3] == 5'h16 && cur_input == adc_cfg_pkg::SEL_AM
		##0 s_one_step |=> cur_input == adc_cfg_pkg::SEL_DIFF_B;
	endproperty
	a_scan_mixed_three: assert property (p_scan_mixed_three)
		else $error("mixed three scan wrong");

	property p_scan_diff2;
		@(posedge core_clk) disable iff (sys_rst)
		input_mode_word[7:3] == 5'h19 && $stable(input_mode_word) &&
		!$past(conv_step) && !$past(wr_mode || wr_host) |->
		cur_input == $past(cur_input);
	endproperty
	a_scan_diff2: assert property (p_scan_diff2)
		else $error("scan moved");

	property p_scan_hold;
		@(posedge core_clk) disable iff (sys_rst)
		!$past(conv_step) && !$past(wr_strobe) && !$past(sys_rst) |->
		$stable(cur_input);
	endproperty
	a_scan_hold: assert property (p_scan_hold)
		else $error("input moved without a step");

	property p_host_write;
		@(posedge core_clk) disable iff (sys_rst)
		wr_host && !wr_data[0] |=> host_if_word[8:2] == $past(wr_data[8:2]) &&
			queue_clear_pulse == $past(wr_data[1]) && !host_if_word[9];
	endproperty
	a_host_write: assert property (p_host_write)
		else $error("host word wrong");

	property p_pulse_once;
		@(posedge core_clk) disable iff (sys_rst)
		queue_clear_pulse && !wr_host |=> !queue_clear_pulse;
	endproperty
	a_pulse_once: assert property (p_pulse_once)
		else $error("queue clear pulse too long");

	property p_ignore_addr;
		@(posedge core_clk) disable iff (sys_rst)
		wr_strobe && register_select_bit1 |=>
		$stable(input_mode_word) && $stable(host_if_word);
	endproperty
	a_ignore_addr: assert property (p_ignore_addr)
		else $error("unused address changed a word");

	property p_test_sel;
		@(posedge core_clk) disable iff (sys_rst)
		wr_mode |=>
		selfcheck_sel == $past(wr_data[adc_cfg_pkg::POS_TEST +: 2]);
	endproperty
	a_test_sel: assert property (p_test_sel)
		else $error("test select wrong");

	property p_flag_normal;
		@(posedge core_clk) disable iff (sys_rst)
		selfcheck_sel == 2'h0 && !$past(sys_rst) |->
		samples_ready_flag == $past(samples_ready_in);
	endproperty
	a_flag_normal: assert property (p_flag_normal)
		else $error("flag does not follow source");

	property p_reset_value;
		@(posedge core_clk) disable iff (sys_rst)
		$past(sys_rst) |-> input_mode_word == adc_cfg_pkg::INPUT_MODE_RST &&
			host_if_word == adc_cfg_pkg::HOST_IF_RST &&
			cur_input == adc_cfg_pkg::SEL_DIFF_A;
	endproperty
	a_reset_value: assert property (p_reset_value)
		else $error("reset values wrong");
endmodule : adc_input_select_and_test_decode

// ==== hw/adc_cfg_pkg.sv ====
package adc_cfg_pkg;
	// register select codes on the two address bits
	localparam logic [1:0] ADDR_INPUT_MODE = 2'h0;
	localparam logic [1:0] ADDR_HOST_IF = 2'h1;
	localparam int WORD_W = 10;
	// input_and_mode_control field positions
	localparam int POS_VREF = 0;
	localparam int POS_MODE = 1;
	localparam int POS_PD = 2;
	localparam int POS_PICK = 3;
	localparam int POS_DIFFERENTIAL_COUNT_BIT0 = 5;
	localparam int POS_DIFFERENTIAL_COUNT_BIT1 = 6;
	localparam int POS_SCAN = 7;
	localparam int POS_TEST = 8;
	// host_interface_control field positions
	localparam int POS_RESET = 0;
	localparam int POS_QCLR = 1;
	localparam int POS_TRIG = 2;
	localparam int POS_FLAG_TYPE = 4;
	localparam int POS_FLAG_POL = 5;
	localparam int POS_STROBE = 6;
	localparam int POS_FORMAT = 7;
	localparam int POS_OFFSET = 8;
	// reset values
	localparam logic [9:0] INPUT_MODE_RST = 10'h020;
	localparam logic [9:0] HOST_IF_RST = 10'h030;

	typedef enum logic [2:0] {
		SEL_AP,
		SEL_AM,
		SEL_BP,
		SEL_BM,
		SEL_DIFF_A,
		SEL_DIFF_B
	} input_sel_t;

	typedef struct packed {
		logic [1:0] selfcheck_sel;
		logic scan;
		logic differential_count_bit1;
		logic differential_count_bit0;
		logic [1:0] input_pick;
		logic power_down;
		logic single_conv;
		logic ext_ref;
	} input_mode_t;

	typedef struct packed {
		logic reserved;
		logic offset_en;
		logic output_number_format;
		logic strobe_rw;
		logic flag_polarity;
		logic flag_pulse;
		logic [1:0] queue_threshold;
		logic overflow_or_queue_clear;
		logic soft_reset;
	} host_if_t;
endpackage : adc_cfg_pkg

// ==== test/host_port_model.sv ====
`timescale 1ns/100ps
module host_port_model (
	input wire logic core_clk,
	output logic wr_strobe,
	output logic register_select_bit1,
	output logic register_select_bit0,
	output logic [9:0] wr_data
);
	initial begin
		wr_strobe = 1'b0;
		{register_select_bit1, register_select_bit0} = 2'h0;
		wr_data = 10'h000;
	end

	// one write cycle; lines show the inverse once released
	task write(input logic [1:0] addr, input logic [9:0] d);
		@(posedge core_clk);
		wr_strobe <= 1'b1;
		{register_select_bit1, register_select_bit0} <= addr;
		wr_data <= d;
		@(posedge core_clk);
		wr_strobe <= 1'b0;
		{register_select_bit1, register_select_bit0} <= ~addr;
		wr_data <= ~d;
	endtask : write
endmodule : host_port_model

// ==== test/adc_input_select_and_test_decode_test.sv ====
`timescale 1ns/100ps
module adc_input_select_and_test_decode_test;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic conv_step = 1'b0;
	logic samples_ready_in = 1'b0;
	logic wr_strobe, register_select_bit1, register_select_bit0;
	logic [9:0] wr_data, input_mode_word, host_if_word, d;
	adc_cfg_pkg::input_sel_t cur_input;
	logic [1:0] selfcheck_sel;
	logic samples_ready_flag, scan_active, soft_reset_pulse, queue_clear_pulse;
	int errors = 0;
	int check_count = 0;
	logic [4:0] cfgs [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
		5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h19};
	int burst;

	initial forever #4 core_clk = ~core_clk;

	host_port_model host_port_model_i (.core_clk(core_clk), .wr_strobe(wr_strobe),
		.register_select_bit1(register_select_bit1),
		.register_select_bit0(register_select_bit0), .wr_data(wr_data));

	adc_input_select_and_test_decode adc_input_select_and_test_decode_i (
		.core_clk(core_clk), .sys_rst(sys_rst), .wr_strobe(wr_strobe),
		.register_select_bit1(register_select_bit1),
		.register_select_bit0(register_select_bit0), .wr_data(wr_data),
		.conv_step(conv_step), .samples_ready_in(samples_ready_in),
		.cur_input(cur_input), .selfcheck_sel(selfcheck_sel),
		.samples_ready_flag(samples_ready_flag), .scan_active(scan_active),
		.input_mode_word(input_mode_word), .host_if_word(host_if_word),
		.soft_reset_pulse(soft_reset_pulse),
		.queue_clear_pulse(queue_clear_pulse));

	// expected input for a channel code at a scan step; nibbles low first
	function automatic logic [9:0] exp_sel(logic [4:0] cfg, int step);
		logic [15:0] s;
		int n;
		case (cfg)
			5'h11: begin s = 16'h0010; n = 2; end
			5'h12: begin s = 16'h0210; n = 3; end
			5'h13: begin s = 16'h3210; n = 4; end
			5'h15: begin s = 16'h0050; n = 2; end
			5'h16: begin s = 16'h0510; n = 3; end
			5'h19: begin s = 16'h0054; n = 2; end
			5'h04, 5'h05: begin s = {12'h000, 4'(cfg)}; n = 1; end
			default: begin s = {14'h0000, cfg[1:0]}; n = 1; end
		endcase
		return {6'h00, s[4 * (step % n) +: 4]};
	endfunction : exp_sel

	task check(input logic [9:0] seen, input logic [9:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task wrap_up;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		wrap_up();
	end

	initial begin
		void'($urandom(2));
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		check(input_mode_word, adc_cfg_pkg::INPUT_MODE_RST);
		check(host_if_word, adc_cfg_pkg::HOST_IF_RST);
		check({7'h00, cur_input}, {7'h00, adc_cfg_pkg::SEL_DIFF_A});
		foreach (cfgs[i]) begin
			d = {2'h0, cfgs[i], 3'($urandom)};
			host_port_model_i.write(adc_cfg_pkg::ADDR_INPUT_MODE, d);
			@(negedge core_clk);
			check(input_mode_word, d);
			check({9'h000, scan_active}, {9'h000, cfgs[i][4]});
			for (int k = 0; k < 6; k++) begin
				check({7'h00, cur_input}, exp_sel(cfgs[i], k));
				@(posedge core_clk) conv_step <= 1'b1;
				@(posedge core_clk) conv_step <= 1'b0;
				@(negedge core_clk);
			end
		end
		host_port_model_i.write(adc_cfg_pkg::ADDR_INPUT_MODE, 10'h098);
		burst = 5 + int'($urandom % 3);
		@(posedge core_clk) conv_step <= 1'b1;
		repeat (burst) @(posedge core_clk);
		conv_step <= 1'b0;
		@(negedge core_clk);
		check({7'h00, cur_input}, exp_sel(5'h13, burst));
		for (int t = 0; t < 4; t++) begin
			host_port_model_i.write(adc_cfg_pkg::ADDR_INPUT_MODE, {2'(t), 8'h20});
			@(negedge core_clk);
			check({8'h00, selfcheck_sel}, 10'(t));
			@(posedge core_clk) samples_ready_in <= 1'b1;
			@(posedge core_clk) samples_ready_in <= 1'b0;
			@(negedge core_clk);
			check({9'h000, samples_ready_flag},
				(t == 0) ? 10'h001 : {9'h000, !adc_cfg_pkg::HOST_IF_RST[5]});
		end
		d = 10'($urandom) & 10'h1fc;
		host_port_model_i.write(adc_cfg_pkg::ADDR_HOST_IF, d | 10'h200);
		host_port_model_i.write(2'h2, 10'($urandom));
		host_port_model_i.write(2'h3, 10'($urandom));
		@(negedge core_clk);
		check(host_if_word, d);
		check(input_mode_word, 10'h320);
		host_port_model_i.write(adc_cfg_pkg::ADDR_HOST_IF, 10'h032);
		@(negedge core_clk);
		check({9'h000, queue_clear_pulse}, 10'h001);
		check(host_if_word, 10'h030);
		@(negedge core_clk);
		check({9'h000, queue_clear_pulse}, 10'h000);
		host_port_model_i.write(adc_cfg_pkg::ADDR_HOST_IF, 10'h0c1);
		@(negedge core_clk);
		check({9'h000, soft_reset_pulse}, 10'h001);
		check(input_mode_word, adc_cfg_pkg::INPUT_MODE_RST);
		check(host_if_word, adc_cfg_pkg::HOST_IF_RST);
		wrap_up();
	end
endmodule : adc_input_select_and_test_decode_test
